// ### hw/bbc_pkg.sv
// Shared constants and types for the buck-boost mode and start-up control
package bbc_pkg;

  // Conversion mode codes as reported in the status field
  typedef enum logic [1:0] {
    BBC_MODE_BUCK = 2'h0,
    BBC_MODE_BOOST = 2'h1,
    BBC_MODE_BUCKBOOST = 2'h2,
    BBC_MODE_REVERSE = 2'h3
  } bbc_mode_e;

  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_MHZ = 100;

  // Debounce figures in milliseconds
  localparam int DEBOUNCE_LONG_MS = 1300;
  localparam int DEBOUNCE_SHORT_MS = 150;
  localparam int DEBOUNCE_LONG_CYC = DEBOUNCE_LONG_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_SHORT_CYC = DEBOUNCE_SHORT_MS * (CLK_HZ / 1000);

  // Config resistor settling wait in microseconds
  localparam int CFG_SETTLE_US = 40;
  localparam int CFG_SETTLE_CYC = CFG_SETTLE_US * CLK_MHZ;

  // Gate non-overlap time in nanoseconds, rounded up to cycles
  localparam int DEAD_NS = 20;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;

  // Cell count codes
  localparam logic [1:0] CELLS_ONE = 2'h1;
  localparam logic [1:0] CELLS_TWO = 2'h2;
  localparam logic [1:0] CELLS_THREE = 2'h3;

  // Input current cap encodings in mA
  localparam logic [12:0] CAP_0P1_MA = 13'h0064;
  localparam logic [12:0] CAP_0P476_MA = 13'h01DC;
  localparam logic [12:0] CAP_1P5_MA = 13'h05DC;
  localparam logic [12:0] CAP_TWO_RESET = CAP_1P5_MA;

  // Frequency select: 0 = 733 kHz, 1 = 1 MHz
  localparam logic FREQ_733K = 1'b0;
  localparam logic FREQ_1M = 1'b1;

  localparam logic [3:0] CFG_RESET = 4'h0;

endpackage : bbc_pkg

// ### hw/bbc_gate_if.sv
// Per-leg PWM request and gate-drive carrier between control and driver
`timescale 1ns/10ps
`default_nettype none
interface bbc_gate_if;
  logic in_pwm;
  logic in_hold_high;
  logic in_hold_low;
  logic out_pwm;
  logic out_hold_high;
  logic out_hold_low;
  logic input_high_fet;
  logic input_low_fet;
  logic output_low_fet;
  logic output_high_fet;
  modport ctrl (
    output in_pwm, in_hold_high, in_hold_low,
    output out_pwm, out_hold_high, out_hold_low,
    input input_high_fet, input_low_fet, output_low_fet, output_high_fet
  );
  modport drv (
    input in_pwm, in_hold_high, in_hold_low,
    input out_pwm, out_hold_high, out_hold_low,
    output input_high_fet, input_low_fet, output_low_fet, output_high_fet
  );
endinterface : bbc_gate_if
`default_nettype wire

// ### hw/bbc_gate_drv.sv
// Two-leg gate driver with non-overlap insertion
`timescale 1ns/10ps
`default_nettype none
module bbc_gate_drv
  import bbc_pkg::*;
#(
  parameter int DEAD = DEAD_CYC
)(
  input wire logic core_clk,
  input wire logic resetn,
  bbc_gate_if.drv g
);

  typedef struct packed {
    logic [1:0] hi;
    logic [1:0] lo;
    logic [1:0][7:0] dead;
  } bbc_drv_s;

  bbc_drv_s st_reg;
  bbc_drv_s st_next;
  logic [1:0] want_hi;
  logic [1:0] want_lo;

  // Leg 0 is the input leg, leg 1 the output leg; hold_low parks a leg with
  // both switches open, so an idle bridge never conducts
  always_comb
  begin
    want_hi[0] = ~g.in_hold_low & (g.in_hold_high | g.in_pwm);
    want_lo[0] = ~g.in_hold_low & ~g.in_hold_high & ~g.in_pwm;
    want_hi[1] = ~g.out_hold_low & (g.out_hold_high | g.out_pwm);
    want_lo[1] = ~g.out_hold_low & ~g.out_hold_high & ~g.out_pwm;
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_leg
    // Break before make: drop both, wait, then close the wanted switch
    always_comb
    begin
      st_next.hi[i] = st_reg.hi[i];
      st_next.lo[i] = st_reg.lo[i];
      st_next.dead[i] = st_reg.dead[i];
      if ((st_reg.hi[i] & ~want_hi[i]) | (st_reg.lo[i] & ~want_lo[i]))
      begin
        st_next.hi[i] = 1'b0;
        st_next.lo[i] = 1'b0;
        st_next.dead[i] = 8'(DEAD);
      end
      else if (st_reg.dead[i] != 8'h00)
        st_next.dead[i] = st_reg.dead[i] - 8'h01;
      else if (!st_reg.hi[i] && !st_reg.lo[i])
      begin
        st_next.hi[i] = want_hi[i];
        st_next.lo[i] = want_lo[i] & ~want_hi[i];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign g.input_high_fet = st_reg.hi[0];
  assign g.input_low_fet = st_reg.lo[0];
  assign g.output_high_fet = st_reg.hi[1];
  assign g.output_low_fet = st_reg.lo[1];

  property p_leg_in_no_overlap;
    @(posedge core_clk) disable iff (!resetn)
      !(g.input_high_fet && g.input_low_fet);
  endproperty
  a_leg_in_no_overlap: assert property (p_leg_in_no_overlap)
    else $error("input leg both on");

  property p_leg_out_gap;
    @(posedge core_clk) disable iff (!resetn)
      $fell(g.output_high_fet) |-> !g.output_low_fet [*2];
  endproperty
  a_leg_out_gap: assert property (p_leg_out_gap)
    else $error("output leg gap missing");

endmodule : bbc_gate_drv
`default_nettype wire

// ### hw/bbc_ctrl.sv
// Mode selection, adapter start-up sequencing and config decode
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Buck: input leg switches, output high on
// - Boost: output leg switches, input high on
// - Buck-boost: diagonal pairs switch together
// - Reverse: output leg switches, input high on
// - Rising above 94% moves boost to buck-boost
// - Above 120% forces buck-boost to buck
// - Falling below 106% moves buck to buck-boost
// - Falling below 80% moves buck-boost to boost
// - Reverse needs command, pin, battery above 5.8V
// - One-cell configuration refuses reverse operation
// - One bit sets adapter gate in reverse
// - Core active once bias exceeds 2.7V
// - Debounce 1.3s or 150ms before adapter gate
// - First insertion after power-on uses 150ms
// - Short on input bus keeps gate off
// - Release adapter-good on bias, sense, gate on
// - Switching starts only after adapter-good or in reverse
// - Adapter-good driven low with no adapter
// - Source current, sample config before gate
// - Battery only enters low power, exits on monitor
// - Config selects cells, frequency, first cap
// - Second cap resets to 1.5A
// - Two-bit field reports conversion mode
// - Four-bit field reports the sampled config code
// - Battery only: sample config after monitor enable
module bbc_ctrl
  import bbc_pkg::*;
#(
  parameter int DEB_LONG = DEBOUNCE_LONG_CYC,
  parameter int DEB_SHORT = DEBOUNCE_SHORT_CYC,
  parameter int CFG_SETTLE = CFG_SETTLE_CYC,
  parameter int DEAD = DEAD_CYC
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic bias_above_2v7,
  input wire logic bias_above_3v8,
  input wire logic adapter_voltage_above_3v2,
  input wire logic adapter_sense_input,
  input wire logic input_current_sense_pos,
  input wire logic adp_above_80pct,
  input wire logic adp_above_94pct,
  input wire logic adp_above_106pct,
  input wire logic adp_above_120pct,
  input wire logic battery_above_5v8,
  input wire logic adapter_gate_full_on,
  input wire logic reverse_power_enable_pin,
  input wire logic reverse_cmd,
  input wire logic reverse_gate_bit,
  input wire logic long_debounce_sel,
  input wire logic platform_power_monitor,
  input wire logic pwm_req,
  input wire logic [3:0] config_code_in,
  input wire logic config_code_valid,
  output logic config_source_en,
  output logic adapter_switch_gate,
  output logic adapter_good_flag_o,
  output logic adapter_good_flag_oe,
  output logic switching_en,
  output logic low_power,
  output logic core_active,
  output logic [1:0] mode_status,
  output logic [3:0] config_status,
  output logic [1:0] cell_count,
  output logic freq_sel,
  output logic [12:0] input_current_cap_one,
  output logic [12:0] input_current_cap_two,
  output logic input_high_fet,
  output logic input_low_fet,
  output logic output_low_fet,
  output logic output_high_fet
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CFG_READ,
    ST_DEBOUNCE,
    ST_GATE,
    ST_GOOD,
    ST_REVERSE
  } bbc_state_e;

  typedef struct packed {
    bbc_state_e state;
    bbc_mode_e mode;
    logic [31:0] count;
    logic first_done;
    logic cfg_read;
    logic [3:0] cfg;
    logic good;
    logic src_en;
    logic [2:0][2:0] sync;
    logic [2:0] pins;
  } bbc_ctrl_s;

  bbc_ctrl_s st_reg;
  bbc_ctrl_s st_next;
  logic [2:0] pin_raw;
  logic [2:0] pin_ok;
  logic adp_det;
  logic rev_ok;
  logic short_ok;
  logic [31:0] deb_len;
  logic [1:0] cfg_cells;
  logic cfg_freq;
  logic [12:0] cfg_cap;

  // Adapter-present, reverse-enable and monitor-enable pins are asynchronous
  assign pin_raw = {platform_power_monitor, reverse_power_enable_pin,
                    adapter_voltage_above_3v2};

  // Change accepted once second and third stage agree
  for (genvar i = 0; i < 3; i++)
  begin : g_pin
    assign pin_ok[i] = (st_reg.sync[1][i] == st_reg.sync[2][i]) ?
                       st_reg.sync[2][i] : st_reg.pins[i];
  end

  assign adp_det = pin_ok[0];
  assign short_ok = input_current_sense_pos & adapter_sense_input;
  assign rev_ok = reverse_cmd & pin_ok[1] & battery_above_5v8
                  & (cfg_cells != CELLS_ONE);
  // First insertion after power-on always uses the short wait
  assign deb_len = (long_debounce_sel && st_reg.first_done) ?
                   32'(DEB_LONG) : 32'(DEB_SHORT);

  // Config code decode: cells, frequency, first cap
  always_comb
  begin
    cfg_cells = CELLS_THREE;
    if (st_reg.cfg >= 4'hA)
      cfg_cells = CELLS_ONE;
    else if (st_reg.cfg >= 4'h5)
      cfg_cells = CELLS_TWO;
    case (st_reg.cfg)
      4'h0, 4'h1, 4'h5, 4'h6, 4'hA, 4'hB, 4'hC: cfg_freq = FREQ_1M;
      default: cfg_freq = FREQ_733K;
    endcase
    case (st_reg.cfg)
      4'h0, 4'h2, 4'h5, 4'h7, 4'hB, 4'hD: cfg_cap = CAP_1P5_MA;
      4'h4, 4'h9, 4'hA, 4'hF: cfg_cap = CAP_0P1_MA;
      default: cfg_cap = CAP_0P476_MA;
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.sync[0] = pin_raw;
    st_next.sync[1] = st_reg.sync[0];
    st_next.sync[2] = st_reg.sync[1];
    st_next.pins = pin_ok;
    st_next.src_en = 1'b0;
    if (st_reg.count != 32'h0)
      st_next.count = st_reg.count - 32'h1;

    // Mode selection with hysteresis; held unless a crossing applies
    if (st_reg.state == ST_REVERSE)
      st_next.mode = BBC_MODE_REVERSE;
    else
      case (st_reg.mode)
        BBC_MODE_BOOST:
          if (adp_above_94pct)
            st_next.mode = BBC_MODE_BUCKBOOST;
        BBC_MODE_BUCKBOOST:
          if (adp_above_120pct)
            st_next.mode = BBC_MODE_BUCK;
          else if (!adp_above_80pct)
            st_next.mode = BBC_MODE_BOOST;
        BBC_MODE_BUCK:
          if (!adp_above_106pct)
            st_next.mode = BBC_MODE_BUCKBOOST;
        default:
          st_next.mode = adp_above_120pct ? BBC_MODE_BUCK :
                         BBC_MODE_BUCKBOOST;
      endcase

    case (st_reg.state)
      ST_IDLE:
      begin
        st_next.good = 1'b0;
        if (!bias_above_2v7)
          st_next.state = ST_IDLE;
        else if (adp_det)
        begin
          st_next.state = ST_CFG_READ;
          st_next.count = 32'(CFG_SETTLE);
        end
        else if (rev_ok)
          st_next.state = ST_REVERSE;
        else if (pin_ok[2] && !st_reg.cfg_read)
        begin
          // Battery only: the monitor enable triggers a config read
          st_next.state = ST_CFG_READ;
          st_next.count = 32'(CFG_SETTLE);
        end
      end
      ST_CFG_READ:
      begin
        st_next.src_en = 1'b1;
        if (st_reg.count == 32'h0 && config_code_valid)
        begin
          st_next.cfg = config_code_in;
          st_next.cfg_read = 1'b1;
          st_next.src_en = 1'b0;
          st_next.count = deb_len;
          st_next.state = adp_det ? ST_DEBOUNCE : ST_IDLE;
        end
      end
      ST_DEBOUNCE:
        if (!adp_det)
          st_next.state = ST_IDLE;
        else if (!short_ok)
          st_next.count = deb_len;
        else if (st_reg.count == 32'h0)
        begin
          st_next.state = ST_GATE;
          st_next.first_done = 1'b1;
        end
      ST_GATE:
        if (!adp_det)
          st_next.state = ST_IDLE;
        else if (bias_above_3v8 && adapter_sense_input
                 && adapter_gate_full_on)
        begin
          st_next.state = ST_GOOD;
          st_next.good = 1'b1;
        end
      ST_GOOD:
        if (!adp_det || !adapter_sense_input || !bias_above_3v8)
        begin
          st_next.state = ST_IDLE;
          st_next.good = 1'b0;
        end
      ST_REVERSE:
        if (adp_det || !rev_ok)
        begin
          st_next.state = ST_IDLE;
          st_next.mode = BBC_MODE_BUCK;
        end
      default:
        st_next.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.mode <= BBC_MODE_BUCK;
      st_reg.cfg <= CFG_RESET;
    end
    else
      st_reg <= st_next;
  end

  // Gate drive: mode picks which leg switches and which is held
  bbc_gate_if gi ();
  logic run;
  bbc_mode_e drive_mode;
  assign run = switching_en;
  // The mode register lags entry to reverse by a cycle; the state does not
  assign drive_mode = (st_reg.state == ST_REVERSE) ? BBC_MODE_REVERSE :
                      st_reg.mode;

  always_comb
  begin
    gi.in_pwm = 1'b0;
    gi.in_hold_high = 1'b0;
    gi.in_hold_low = 1'b1;
    gi.out_pwm = 1'b0;
    gi.out_hold_high = 1'b0;
    gi.out_hold_low = 1'b1;
    if (run)
      case (drive_mode)
        BBC_MODE_BUCK:
        begin
          gi.in_pwm = pwm_req;
          gi.in_hold_low = 1'b0;
          gi.out_hold_high = 1'b1;
          gi.out_hold_low = 1'b0;
        end
        BBC_MODE_BOOST:
        begin
          gi.in_hold_high = 1'b1;
          gi.in_hold_low = 1'b0;
          gi.out_pwm = ~pwm_req;
          gi.out_hold_low = 1'b0;
        end
        BBC_MODE_BUCKBOOST:
        begin
          // Control pair is input high with output low
          gi.in_pwm = pwm_req;
          gi.in_hold_low = 1'b0;
          gi.out_pwm = ~pwm_req;
          gi.out_hold_low = 1'b0;
        end
        default:
        begin
          gi.in_hold_high = 1'b1;
          gi.in_hold_low = 1'b0;
          gi.out_pwm = pwm_req;
          gi.out_hold_low = 1'b0;
        end
      endcase
  end

  bbc_gate_drv #(
    .DEAD(DEAD)
  ) u_drv (
    .core_clk(core_clk),
    .resetn(resetn),
    .g(gi.drv)
  );

  assign input_high_fet = gi.input_high_fet;
  assign input_low_fet = gi.input_low_fet;
  assign output_low_fet = gi.output_low_fet;
  assign output_high_fet = gi.output_high_fet;

  // Switching only once adapter-good is out, or in reverse operation
  assign switching_en = st_reg.good | (st_reg.state == ST_REVERSE);
  // Reverse operation hands the adapter gate to one control bit
  assign adapter_switch_gate = (st_reg.state == ST_REVERSE) ?
                               reverse_gate_bit :
                               (st_reg.state == ST_GATE ||
                                st_reg.state == ST_GOOD);
  assign adapter_good_flag_o = 1'b0;
  assign adapter_good_flag_oe = ~st_reg.good;
  assign config_source_en = st_reg.src_en;
  assign core_active = bias_above_2v7 & resetn;
  assign low_power = (st_reg.state == ST_IDLE) & ~adp_det & ~pin_ok[2];
  assign mode_status = st_reg.mode;
  assign config_status = st_reg.cfg;
  assign cell_count = cfg_cells;
  assign freq_sel = cfg_freq;
  assign input_current_cap_one = cfg_cap;
  assign input_current_cap_two = CAP_TWO_RESET;

  sequence s_good_up;
    $rose(st_reg.good);
  endsequence

  property p_switch_after_good;
    @(posedge core_clk) disable iff (!resetn)
      !switching_en |=> !input_high_fet && !input_low_fet
        && !output_low_fet && !output_high_fet;
  endproperty
  a_switch_after_good: assert property (p_switch_after_good)
    else $error("gates driven before adapter-good");

  property p_good_cause;
    @(posedge core_clk) disable iff (!resetn)
      s_good_up |-> $past(bias_above_3v8) && $past(adapter_gate_full_on);
  endproperty
  a_good_cause: assert property (p_good_cause)
    else $error("adapter-good without its conditions");

  property p_force_buck;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg.mode == BBC_MODE_BUCKBOOST && adp_above_120pct
       && st_reg.state != ST_REVERSE) |=> st_reg.mode == BBC_MODE_BUCK;
  endproperty
  a_force_buck: assert property (p_force_buck)
    else $error("no forced buck above 120 percent");

  property p_boost_up;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg.mode == BBC_MODE_BOOST && adp_above_94pct
       && st_reg.state != ST_REVERSE) |=> st_reg.mode == BBC_MODE_BUCKBOOST;
  endproperty
  a_boost_up: assert property (p_boost_up)
    else $error("boost did not rise to buck-boost");

  property p_buck_down;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg.mode == BBC_MODE_BUCK && !adp_above_106pct
       && st_reg.state != ST_REVERSE) |=> st_reg.mode == BBC_MODE_BUCKBOOST;
  endproperty
  a_buck_down: assert property (p_buck_down)
    else $error("buck did not fall to buck-boost");

  property p_bb_down;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg.mode == BBC_MODE_BUCKBOOST && !adp_above_80pct
       && !adp_above_120pct && st_reg.state != ST_REVERSE)
        |=> st_reg.mode == BBC_MODE_BOOST;
  endproperty
  a_bb_down: assert property (p_bb_down)
    else $error("buck-boost did not fall to boost");

  property p_no_rev_one_cell;
    @(posedge core_clk) disable iff (!resetn)
      (cfg_cells == CELLS_ONE && st_reg.state == ST_IDLE)
        |=> st_reg.state != ST_REVERSE;
  endproperty
  a_no_rev_one_cell: assert property (p_no_rev_one_cell)
    else $error("reverse entered with one cell");

  property p_buck_hold;
    @(posedge core_clk) disable iff (!resetn)
      (run && st_reg.mode == BBC_MODE_BUCK) [*8] |-> output_high_fet
        && !output_low_fet;
  endproperty
  a_buck_hold: assert property (p_buck_hold)
    else $error("buck output leg not held");

  property p_short_hold;
    @(posedge core_clk) disable iff (!resetn)
      (st_reg.state == ST_DEBOUNCE && !short_ok)
        |=> st_reg.state != ST_GATE;
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("gate opened during input short");

endmodule : bbc_ctrl
`default_nettype wire

// ### dv/bbc_bridge_model.sv
// Behavioural model of the external FET bridge and adapter switch
`timescale 1ns/10ps
`default_nettype none
module bbc_bridge_model
#(
  parameter int RAMP = 4
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] fets,
  input wire logic adapter_switch_gate,
  output logic adapter_gate_full_on,
  output logic [15:0] overlaps
);
  int ramp_cnt;
  // The switch gate charges slowly, so full-on lags the drive
  always_ff @(posedge core_clk)
  begin
    if (!resetn || !adapter_switch_gate)
      ramp_cnt <= 0;
    else if (ramp_cnt < RAMP)
      ramp_cnt <= ramp_cnt + 1;
  end
  assign adapter_gate_full_on = (ramp_cnt == RAMP);
  // Shoot-through in either leg is counted rather than modelled
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      overlaps <= 16'h0;
    else if ((fets[3] && fets[2]) || (fets[1] && fets[0]))
      overlaps <= overlaps + 16'h1;
  end
endmodule : bbc_bridge_model
`default_nettype wire

// ### dv/test_buck_boost_mode_and_startup_ctrl.sv
// Self-checking bench for the mode and start-up control
`timescale 1ns/10ps
`default_nettype none
module test_buck_boost_mode_and_startup_ctrl;
  import bbc_pkg::*;
  localparam int DL = 50;
  localparam int DS = 20;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic b27 = 1'b0, b38 = 1'b1, adp = 1'b0, sense = 1'b1, spos = 1'b1;
  logic bat = 1'b0, rpin = 1'b0, rcmd = 1'b0, rgate = 1'b0, lsel = 1'b1;
  logic mon = 1'b0, pwm = 1'b0, cvalid = 1'b0;
  logic [3:0] thr = 4'hF;
  logic [3:0] code = 4'h0;
  wire logic full_on, src_en, gate, good_o, good_oe, sw_en, lp, core_act;
  wire logic freq;
  wire logic [1:0] mode, cells;
  wire logic [3:0] cfg, fets;
  wire logic [12:0] cap1, cap2;
  wire logic [15:0] overlaps;
  int mismatches = 0;
  int total_checks = 0;
  logic [31:0] rng = 32'h574;
  logic [1:0] exp_q[$];
  logic [1:0] mode_prev = 2'h0;
  logic [3:0] codes[3] = '{4'h6, 4'hB, 4'h4};
  logic [1:0] ncell[3] = '{2'h2, 2'h1, 2'h3};
  logic nfreq[3] = '{1'b1, 1'b1, 1'b0};
  logic [12:0] ncap[3] = '{13'h01DC, 13'h05DC, 13'h0064};
  logic [3:0] steps[8] = '{4'h7, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
  logic [1:0] smode[8] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};

  always #5 core_clk = ~core_clk;

  bbc_ctrl #(.DEB_LONG(DL), .DEB_SHORT(DS), .CFG_SETTLE(5), .DEAD(2))
  u_dut (
    .core_clk(core_clk), .resetn(resetn), .bias_above_2v7(b27),
    .bias_above_3v8(b38), .adapter_voltage_above_3v2(adp),
    .adapter_sense_input(sense), .input_current_sense_pos(spos),
    .adp_above_80pct(thr[0]), .adp_above_94pct(thr[1]),
    .adp_above_106pct(thr[2]), .adp_above_120pct(thr[3]),
    .battery_above_5v8(bat), .adapter_gate_full_on(full_on),
    .reverse_power_enable_pin(rpin), .reverse_cmd(rcmd),
    .reverse_gate_bit(rgate), .long_debounce_sel(lsel),
    .platform_power_monitor(mon), .pwm_req(pwm), .config_code_in(code),
    .config_code_valid(cvalid), .config_source_en(src_en),
    .adapter_switch_gate(gate), .adapter_good_flag_o(good_o),
    .adapter_good_flag_oe(good_oe), .switching_en(sw_en),
    .low_power(lp), .core_active(core_act), .mode_status(mode),
    .config_status(cfg), .cell_count(cells), .freq_sel(freq),
    .input_current_cap_one(cap1), .input_current_cap_two(cap2),
    .input_high_fet(fets[3]), .input_low_fet(fets[2]),
    .output_low_fet(fets[1]), .output_high_fet(fets[0])
  );

  bbc_bridge_model u_bridge (
    .core_clk(core_clk), .resetn(resetn), .fets(fets),
    .adapter_switch_gate(gate), .adapter_gate_full_on(full_on),
    .overlaps(overlaps)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Gate pattern per mode, as {in_high, in_low, out_low, out_high}
  function automatic logic [3:0] fexp(input logic [1:0] m, input logic v);
    case (m)
      BBC_MODE_BUCK: return {v, ~v, 1'b0, 1'b1};
      BBC_MODE_BOOST: return {1'b1, 1'b0, v, ~v};
      BBC_MODE_BUCKBOOST: return {v, ~v, v, ~v};
      default: return {1'b1, 1'b0, ~v, v};
    endcase
  endfunction : fexp

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // Bounded wait on gate (0), good pull-down (1) or config sourcing (2)
  task automatic wait_for(input int sel, input logic val, output int n);
    logic s;
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
      s = (sel == 0) ? gate : (sel == 1) ? good_oe : src_en;
      if (n > 400)
      begin
        mismatches++;
        $display("ERROR at %0t: wait ran out", $time);
        test_done();
      end
    end while (s !== val);
  endtask : wait_for

  task automatic run_pwm(input logic [1:0] m);
    repeat (6)
    begin
      @(negedge core_clk);
      rng = xs(rng);
      pwm = rng[0];
    end
    repeat (8) @(negedge core_clk);
    check(13'(fets), 13'(fexp(m, pwm)));
  endtask : run_pwm

  task automatic insert(input logic shorted, output int n);
    int k;
    adp = 1'b1;
    if (shorted)
    begin
      spos = 1'b0;
      repeat (DL + 10)
      begin
        @(negedge core_clk);
        check(13'(gate), 13'h0);
      end
      spos = 1'b1;
    end
    wait_for(0, 1'b1, n);
    check(13'(good_oe), 13'h1);
    check(13'(sw_en), 13'h0);
    wait_for(1, 1'b0, k);
    check(13'(full_on), 13'h1);
    check(13'(sw_en), 13'h1);
  endtask : insert

  task automatic remove();
    adp = 1'b0;
    repeat (8) @(negedge core_clk);
    check(13'(good_oe), 13'h1);
    check(13'(good_o), 13'h0);
    check(13'(sw_en), 13'h0);
    check(13'(fets), 13'h0);
  endtask : remove

  // Each change of the reported mode consumes the oldest expectation
  always @(negedge core_clk)
  begin
    if (resetn && mode !== mode_prev)
    begin
      if (exp_q.size() == 0)
        check(13'(mode), 13'(mode_prev));
      else
        check(13'(mode), 13'(exp_q.pop_front()));
    end
    mode_prev <= mode;
  end

  initial
  begin
    int n;
    for (int i = 0; i < 3; i++)
    begin
      resetn = 1'b0;
      {rcmd, rpin, mon, adp, b27, cvalid, thr} = {6'h0, 4'hF};
      code = codes[i];
      repeat (20) @(negedge core_clk);
      resetn = 1'b1;
      bat = 1'b1;
      repeat (4) @(negedge core_clk);
      check(13'(core_act), 13'h0);
      b27 = 1'b1;
      repeat (20) @(negedge core_clk);
      check(13'(core_act), 13'h1);
      check(cap2, CAP_TWO_RESET);
      check(13'(cfg), 13'(CFG_RESET));
      check(13'(src_en), 13'h0);
      check(13'(lp), 13'h1);
      mon = 1'b1;
      wait_for(2, 1'b1, n);
      check(13'(lp), 13'h0);
      repeat (12) @(negedge core_clk);
      check(13'(src_en), 13'h1);
      check(13'(gate), 13'h0);
      cvalid = 1'b1;
      wait_for(2, 1'b0, n);
      mon = 1'b0;
      check(13'(cfg), 13'(codes[i]));
      check(13'(cells), 13'(ncell[i]));
      check(13'(freq), 13'(nfreq[i]));
      check(cap1, ncap[i]);
      lsel = 1'b1;
      insert(1'b0, n);
      check(13'(n >= DS && n < DL), 13'h1);
      for (int k = 0; k < 8; k++)
      begin
        thr = steps[k];
        if (smode[k] != mode_prev)
          exp_q.push_back(smode[k]);
        run_pwm(smode[k]);
      end
      remove();
      insert(1'b1, n);
      check(13'(n >= DL), 13'h1);
      remove();
      lsel = 1'b0;
      insert(1'b0, n);
      check(13'(n < DL), 13'h1);
      remove();
      {rcmd, bat} = 2'h3;
      repeat (10) @(negedge core_clk);
      check(13'(mode), 13'(BBC_MODE_BUCK));
      {rpin, bat} = 2'h2;
      repeat (10) @(negedge core_clk);
      check(13'(mode), 13'(BBC_MODE_BUCK));
      bat = 1'b1;
      if (ncell[i] != CELLS_ONE)
        exp_q.push_back(BBC_MODE_REVERSE);
      repeat (10) @(negedge core_clk);
      if (ncell[i] == CELLS_ONE)
        check(13'(mode), 13'(BBC_MODE_BUCK));
      else
      begin
        run_pwm(BBC_MODE_REVERSE);
        repeat (3)
        begin
          rng = xs(rng);
          rgate = rng[1];
          repeat (2) @(negedge core_clk);
          check(13'(gate), 13'(rgate));
        end
      end
    end
    check(13'(exp_q.size()), 13'h0);
    check(13'(overlaps != 16'h0), 13'h0);
    test_done();
  end
endmodule : test_buck_boost_mode_and_startup_ctrl
`default_nettype wire
